// [core/serial_word_pkg.sv]
// Constants and types of the two-channel converter serial word logic.
// Assumes a single 40 MHz system clock; pins are asynchronous to it.
// What this block does
// - Each result leaves as a sixteen-bit word whose first two bits are zero.
// - Twelve-bit variant: zeros, channel bit, mode flag, then result MSB first.
// - Ten-bit variant: same header, ten-bit result MSB first, then two zeros.
// - The first output bit is driven at select fall; each later bit is shifted out on a falling serial clock edge.
// - Input data is sampled on falling serial clock edges during the transfer.
// - Only the third and fourth input bits are used; all others are ignored.
// - Third input bit picks the next channel: zero or one.
// - Fourth bit differing from the third keeps daisy-chain mode.
// - Fourth bit equal to the third returns to normal mode next cycle.
// - Channel bit and mode flag match in normal mode, differ in daisy chain.
// - Output channel bit names the input actually converted for this word.
// - Select released after 10th, before 12th fall: end, release, enter chain.
// - Select released after 2nd, before 10th fall: abort, release, power down.
package serial_word_pkg;

  localparam int WORD_BITS = 16;
  localparam int FIELD_BITS = 12;
  localparam logic [4:0] CHAN_FALL = 5'h03;
  localparam logic [4:0] KEEP_FALL = 5'h04;
  localparam logic [4:0] DOWN_MIN_FALLS = 5'h02;
  localparam logic [4:0] CHAIN_MIN_FALLS = 5'h0A;
  localparam logic [4:0] CHAIN_END_FALLS = 5'h0C;
  localparam logic [4:0] MAX_FALLS = 5'h10;
  localparam logic RST_CHAN = 1'h0;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_CHAIN,
    MODE_DOWN
  } mode_t;

  typedef struct packed {
    mode_t mode;
    logic chan;
    logic active;
    logic [4:0] cnt;
    logic [WORD_BITS-1:0] word;
    logic rx_chan;
    logic rx_keep;
    logic sdo;
    logic oe;
    logic strobe;
    logic chain_out;
    logic down_out;
  } core_state_t;

  typedef struct packed {
    logic [1:0] cs_s;
    logic [2:0] sclk_s;
    logic [1:0] sdi_s;
    logic cs_old;
  } front_state_t;

endpackage

// [core/pin_event_if.sv]
// Events recovered from the serial pins, passed from the pin front end to the core.
// Assumes both ends run on the system clock.
`timescale 1ns/1ps
interface pin_event_if;
  logic cs_fall;
  logic cs_rise;
  logic cs_low;
  logic sclk_fall;
  logic sdi;

  modport front
  (
    output cs_fall,
    output cs_rise,
    output cs_low,
    output sclk_fall,
    output sdi
  );

  modport core
  (
    input cs_fall,
    input cs_rise,
    input cs_low,
    input sclk_fall,
    input sdi
  );
endinterface

// [core/pin_front.sv]
// Two-stage synchronisers and edge finders for select, serial clock and data in.
// Assumes pin clocks are well below half the system clock rate.
`timescale 1ns/1ps
module pin_front
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic sdi_pin,
  pin_event_if.front ev
);
  import serial_word_pkg::*;

  front_state_t st_q;
  front_state_t st_d;

  // ****************************************
  // Synchronise, then compare settled stages
  // ****************************************
  // Edge finders look only at second and later stages, never the first flop
  always_comb
  begin
    st_d = st_q;
    st_d.cs_s = {st_q.cs_s[0], cs_n_pin};
    st_d.sclk_s = {st_q.sclk_s[1:0], sclk_pin};
    st_d.sdi_s = {st_q.sdi_s[0], sdi_pin};
    st_d.cs_old = st_q.cs_s[1];
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      st_q <= '{cs_s: 2'h3, sclk_s: 3'h0, sdi_s: 2'h0, cs_old: 1'h1};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Select edges and falling serial clock as one-cycle events
  assign ev.cs_low = !st_q.cs_s[1];
  assign ev.cs_fall = st_q.cs_old && !st_q.cs_s[1];
  assign ev.cs_rise = !st_q.cs_old && st_q.cs_s[1];
  assign ev.sclk_fall = st_q.sclk_s[2] && !st_q.sclk_s[1];
  assign ev.sdi = st_q.sdi_s[1];
endmodule

// [core/serial_word_core.sv]
// Serial word logic of a two-channel successive approximation converter.
// Assumes the analog core holds conv_code steady for the channel on sample_channel.
`timescale 1ns/1ps
module serial_word_core #(
  parameter int RES_BITS = 12
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic sdi_pin,
  output logic sdo_o,
  output logic sdo_oe,
  input wire logic [RES_BITS-1:0] conv_code,
  output logic sample_strobe,
  output logic sample_channel,
  output logic chain_mode,
  output logic power_down
);
  import serial_word_pkg::*;

  localparam int PAD_BITS = serial_word_pkg::FIELD_BITS - RES_BITS;
  // Fall count from which only trailing zeros leave the word
  localparam logic [4:0] PAD_FROM = 5'(WORD_BITS - PAD_BITS);

  pin_event_if ev();
  core_state_t st_q;
  core_state_t st_d;
  logic [FIELD_BITS-1:0] res_field;
  logic word_flag;

  pin_front u_front
  (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .cs_n_pin(cs_n_pin),
    .sclk_pin(sclk_pin),
    .sdi_pin(sdi_pin),
    .ev(ev.front)
  );

  // ****************************************
  // Word assembly
  // ****************************************
  // Short result sits left-aligned; the low bits left over become trailing zeros
  assign res_field = FIELD_BITS'(conv_code) << PAD_BITS;
  // Flag equals channel in normal mode and is its inverse in daisy chain
  assign word_flag = st_q.chan ^ (st_q.mode == MODE_CHAIN);

  // ****************************************
  // Transfer and mode control
  // ****************************************
  // One process covers a whole frame: start, bit steps, and the end decision
  always_comb
  begin
    st_d = st_q;
    st_d.strobe = 1'b0;
    if (ev.cs_fall)
    begin
      // Converted channel is the one chosen by the previous frame
      st_d.word = {2'b00, st_q.chan, word_flag, res_field};
      st_d.sdo = 1'b0;
      st_d.oe = 1'b1;
      st_d.active = 1'b1;
      st_d.cnt = 5'h00;
      st_d.strobe = 1'b1;
      st_d.rx_chan = st_q.chan;
      st_d.rx_keep = st_q.chan;
    end
    else if (st_q.active && ev.cs_rise)
    begin
      st_d.active = 1'b0;
      st_d.oe = 1'b0;
      st_d.sdo = 1'b0;
      // New channel only if its bit actually arrived
      if (st_q.cnt >= CHAN_FALL)
      begin
        st_d.chan = st_q.rx_chan;
      end
      if (st_q.cnt < DOWN_MIN_FALLS)
      begin
        st_d.mode = st_q.mode; // Glitch guard: too early to change anything
      end
      else if (st_q.cnt < CHAIN_MIN_FALLS)
      begin
        st_d.mode = MODE_DOWN;
      end
      else if (st_q.cnt < CHAIN_END_FALLS)
      begin
        st_d.mode = MODE_CHAIN;
      end
      else if (st_q.mode == MODE_CHAIN && st_q.rx_keep != st_q.rx_chan)
      begin
        st_d.mode = MODE_CHAIN;
      end
      else
      begin
        st_d.mode = MODE_NORMAL;
      end
    end
    else if (st_q.active && ev.sclk_fall && ev.cs_low)
    begin
      // Counter saturates so clocks beyond the word still count as a full frame
      if (st_q.cnt != MAX_FALLS)
      begin
        st_d.cnt = st_q.cnt + 5'h01;
      end
      st_d.word = {st_q.word[WORD_BITS-2:0], 1'b0};
      st_d.sdo = st_q.word[WORD_BITS-2];
      // Only positions three and four are kept
      if (st_q.cnt + 5'h01 == CHAN_FALL)
      begin
        st_d.rx_chan = ev.sdi;
      end
      if (st_q.cnt + 5'h01 == KEEP_FALL)
      begin
        st_d.rx_keep = ev.sdi;
      end
    end
    // Mode outputs get flops of their own so no decode sits behind a pin
    st_d.chain_out = (st_d.mode == MODE_CHAIN);
    st_d.down_out = (st_d.mode == MODE_DOWN);
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      st_q <= '{mode: MODE_NORMAL, chan: RST_CHAN, active: 1'b0, cnt: 5'h00,
                word: 16'h0000, rx_chan: RST_CHAN, rx_keep: RST_CHAN, sdo: 1'b0,
                oe: 1'b0, strobe: 1'b0, chain_out: 1'b0, down_out: 1'b0};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Every output straight from a state flop
  assign sdo_o = st_q.sdo;
  assign sdo_oe = st_q.oe;
  assign sample_strobe = st_q.strobe;
  assign sample_channel = st_q.chan;
  assign chain_mode = st_q.chain_out;
  assign power_down = st_q.down_out;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  logic flag_at_start;
  logic chan_at_start;
  always_ff @(posedge clk_sys)
  begin
    if (ev.cs_fall)
    begin
      flag_at_start <= word_flag;
      chan_at_start <= st_q.chan;
    end
  end

  a_start_zero: assert property (ev.cs_fall |=> sdo_oe && !sdo_o)
    else $error("output not driving zero after select fall");
  a_release_high: assert property (st_q.active && ev.cs_rise |=> !sdo_oe)
    else $error("output still driven after select rise");
  a_second_zero: assert property (sdo_oe && st_q.cnt == 5'h01 |-> !sdo_o)
    else $error("second header bit not zero");
  a_chan_bit: assert property (sdo_oe && st_q.cnt == 5'h02 |-> sdo_o == chan_at_start)
    else $error("channel bit wrong");
  a_flag_bit: assert property (sdo_oe && st_q.cnt == 5'h03 |-> sdo_o == flag_at_start)
    else $error("mode flag wrong");
  a_step_on_fall: assert property (st_q.active && ev.sclk_fall && ev.cs_low && !ev.cs_rise
    && st_q.cnt < 5'h05 |=> st_q.cnt == $past(st_q.cnt) + 5'h01)
    else $error("bit counter did not step on clock fall");
  a_down_entry: assert property (st_q.active && ev.cs_rise && st_q.cnt >= DOWN_MIN_FALLS
    && st_q.cnt < CHAIN_MIN_FALLS |=> power_down)
    else $error("power-down not entered");
  a_chain_entry: assert property (st_q.active && ev.cs_rise && st_q.cnt >= CHAIN_MIN_FALLS
    && st_q.cnt < CHAIN_END_FALLS |=> chain_mode ##1 chain_mode)
    else $error("daisy chain not entered");
  a_normal_return: assert property (st_q.active && ev.cs_rise && st_q.cnt >= CHAIN_END_FALLS
    && st_q.rx_keep == st_q.rx_chan |=> !chain_mode && !power_down)
    else $error("normal mode not restored");
  a_chan_latch: assert property (st_q.active && ev.cs_rise && st_q.cnt >= CHAN_FALL
    |=> sample_channel == $past(st_q.rx_chan))
    else $error("channel choice not applied");

  // ****************************************
  // Mode bookkeeping and padding
  // ****************************************
  // Mode and channel may only move at the end of a frame, never mid-word
  a_mode_hold: assert property (!(st_q.active && ev.cs_rise)
    |=> $stable(chain_mode) && $stable(power_down))
    else $error("mode changed inside a frame");
  a_chan_hold: assert property (!(st_q.active && ev.cs_rise)
    |=> $stable(sample_channel))
    else $error("channel changed inside a frame");
  a_rx_ignore: assert property (st_q.active && ev.sclk_fall && ev.cs_low
    && st_q.cnt != 5'h02 |=> $stable(st_q.rx_chan))
    else $error("channel choice taken from a wrong input bit");
  a_keep_chain: assert property (st_q.active && ev.cs_rise && chain_mode
    && st_q.cnt >= CHAIN_END_FALLS && st_q.rx_keep != st_q.rx_chan |=> chain_mode)
    else $error("daisy chain not kept");
  // Short variant pads with zeros; the full variant has only shifted-in zeros here
  a_pad_zero: assert property (sdo_oe && st_q.cnt >= PAD_FROM |-> !sdo_o)
    else $error("trailing bit not zero");
  a_strobe_pulse: assert property (sample_strobe |=> !sample_strobe)
    else $error("sample strobe longer than one cycle");
  a_oe_idle: assert property (!ev.cs_low && !st_q.active |-> !sdo_oe)
    else $error("output driven with select high");

  c_full_word: cover property (st_q.active && st_q.cnt == MAX_FALLS ##1 ev.cs_rise);
  c_chain_kept: cover property (chain_mode && ev.cs_rise && st_q.cnt == MAX_FALLS
    && st_q.rx_keep != st_q.rx_chan);
  c_power_down: cover property (!power_down ##1 power_down);
  c_chain_entry: cover property (st_q.active && ev.cs_rise && st_q.cnt == CHAIN_MIN_FALLS);
endmodule

// [sim/host_model.sv]
// Host serial master model: drives select, serial clock and data in, reads data out.
// Assumes the bench gives it data out and its enable; the clock idles low between frames.
`timescale 1ns/1ps
module host_model
(
  output logic cs_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo_o,
  input wire logic sdo_oe
);
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end

  // One frame of n falls (n at most 16); a bit read while released comes back unknown
  task automatic frame(input int n, input logic [15:0] din, output logic [15:0] rx);
    rx = 16'h0000;
    cs_n = 1'b0;
    #100;
    for (int k = 0; k < n; k++)
    begin
      sclk = 1'b1;
      sdi = din[15-k];
      // Read mid-high, one nanosecond after a rising system clock edge
      #50;
      rx[15-k] = sdo_oe ? sdo_o : 1'bx;
      #50;
      sclk = 1'b0;
      #100;
    end
    // Select rises between falls, so the fall count decides the mode
    cs_n = 1'b1;
    sdi = ~sdi;
    #400;
  endtask
endmodule

// [sim/testbench.sv]
// Self-checking bench of the serial word logic against a frame-level reference model.
// Assumes a 40 MHz system clock and a 12-bit result.
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [11:0] conv_code = 12'h000;
  wire cs_n;
  wire sclk;
  wire sdi;
  logic sdo_o, sdo_oe, sample_strobe, sample_channel, chain_mode, power_down;
  logic sdo_short, oe_short;
  logic [15:0] rx_short = 16'h0000;
  int miscompares = 0;
  int samples_checked = 0;
  int strobes = 0;
  logic strobe_chan = 1'b0;
  logic [31:0] rng = 32'h142F;
  int mode = 0; // Reference mode: 0 normal, 1 chain, 2 down
  logic chan = 1'b0;
  logic [15:0] din;
  int ns[13] = '{16, 11, 16, 16, 5, 8, 1, 16, 12, 10, 13, 2, 16};

  always #12.5 clk_sys = ~clk_sys;

  serial_word_core #(.RES_BITS(12)) u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .cs_n_pin(cs_n), .sclk_pin(sclk), .sdi_pin(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .conv_code(conv_code), .sample_strobe(sample_strobe), .sample_channel(sample_channel),
    .chain_mode(chain_mode), .power_down(power_down));
  host_model u_host (.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe));

  // Ten-bit variant listens on the same pins; only its data word is compared
  serial_word_core #(.RES_BITS(10)) u_dut_short (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .cs_n_pin(cs_n), .sclk_pin(sclk), .sdi_pin(sdi), .sdo_o(sdo_short), .sdo_oe(oe_short),
    .conv_code(conv_code[9:0]), .sample_strobe(), .sample_channel(), .chain_mode(),
    .power_down());

  // Read at rising serial clock, where the output has long settled
  always @(posedge sclk)
  begin
    rx_short <= {rx_short[14:0], oe_short ? sdo_short : 1'bx};
  end

  // Count frame-start pulses and keep the channel shown with them
  always @(posedge clk_sys)
  begin
    if (sample_strobe === 1'b1)
    begin
      strobes++;
      strobe_chan = sample_channel;
    end
  end

  // ************************************
  // Helpers
  // ************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  // One frame; only bits actually clocked out are compared, since short frames truncate
  task automatic run(input int n, input logic [15:0] d);
    logic [15:0] rx;
    logic [15:0] exp;
    logic [15:0] mask;
    logic [15:0] exp_short;
    @(posedge clk_sys);
    #1;
    rng = xs(rng);
    conv_code = rng[11:0];
    exp = {2'b00, chan, (mode == 1) ? ~chan : chan, rng[11:0]};
    exp_short = {exp[15:12], rng[9:0], 2'b00};
    mask = ~(16'hFFFF >> n);
    strobes = 0;
    u_host.frame(n, d, rx);
    if (mode != 2)
      check("data word", exp & mask, rx & mask);
    if (mode != 2)
      check("short word", exp_short & mask, (rx_short << (16 - n)) & mask);
    check("strobe count", 16'h0001, 16'(strobes));
    check("sampled channel", {15'h0, chan}, {15'h0, strobe_chan});
    if (n >= 3)
      chan = d[13];
    if (n >= 2 && n <= 9)
      mode = 2;
    else if (n >= 10 && n <= 11)
      mode = 1;
    else if (n >= 12)
      mode = (mode == 1 && d[12] != d[13]) ? 1 : 0;
    check("release", 16'h0000, {15'h0, sdo_oe});
    check("channel", {15'h0, chan}, {15'h0, sample_channel});
    check("chain", {15'h0, mode == 1}, {15'h0, chain_mode});
    check("down", {15'h0, mode == 2}, {15'h0, power_down});
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ************************************
  // Sequence
  // ************************************
  // Watchdog: the whole run must fit well under this bound
  initial
  begin
    #1000000;
    miscompares++;
    $display("unexpected run length: expected end seen none");
    end_of_test();
  end

  // Fixed counts walk each mode change except power-down to daisy chain, then random counts and data words
  initial
  begin
    repeat (4) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    for (int i = 0; i < 37; i++)
    begin
      // Second reset between frames: the reference returns to its power-on state
      if (i == 20)
      begin
        @(posedge clk_sys);
        #1;
        sys_rst = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        mode = 0;
        chan = 1'b0;
        check("reset", 16'h0, {12'h0, sdo_oe, sample_channel, chain_mode, power_down});
      end
      rng = xs(rng);
      din = rng[31:16];
      din[12] = din[13] ^ rng[0];
      run((i < 13) ? ns[i] : 1 + int'(rng[7:4]), din);
    end
    end_of_test();
  end
endmodule
